// ---- include/alarm_pkg.sv ----
/*
 * Constants, codes and timing for the alarm and indicator controller.
 * Assumes a single 10 MHz core clock; all slow timing runs on a 10 ms tick.
 */
// ==========================================================
// Summary of operation
// - Low battery: no sound, battery indicator lit steadily.
// - Critical battery sounds medium tone unless a high patient alarm is active or latched.
// - Critical battery blinks battery indicator, keeps latched alarm, blanks the rest.
// - Critical battery re-enables sound; medium tone unless a high condition is active or latched.
// - Saturation or rate limit: high alarm, numeric blinks; latched shows three dashes.
// - Poor pulse quality: high alarm, red blinking indicator, latchable on critical battery.
// - No breath: high alarm, no breath indicator flashes, bar graph stays active.
// - Critical battery blanks the bar graph even during a no breath alarm.
// - Oximeter fault: dash in leftmost saturation digit, numerics frozen ten seconds.
// - Ten seconds later, middle digit dashes on saturation and rate displays.
// - Oximeter fault sounds medium tone; dashes blink if oximeter alarms were latched.
// - Carbon dioxide fault: medium tone, bars three and six lit, latched no breath blinks.
// - A five mmHg rise marks a breath; exactly one breath beep per breath.
// - During an alarm, breath beeps only sound in the silent gap after a burst.
// - Variable pitch default: pitch follows bar count, beep on falling edge.
// - Fixed pitch beep uses a tone above the highest bar pitch.
// - Fixed pitch beep sounds on the rising edge during exhalation.
// - Power-on and volume beeps always use the fixed pitch.
// - Volume resets to medium; advance press cycles low, medium, high, off.
// - Each press beeps at the new volume unless an alarm is in progress.
// - Beep volume setting never changes alarm loudness.
// - High tone: three beeps, pause, two beeps, repeat after a second, every ten seconds.
// - Medium tone: three medium-long beeps in a second, every twenty-five seconds.
// - Only one tone sounds at a time, chosen by priority.
// ==========================================================
package alarm_pkg;

	// ==========================================================
	// clock and tick timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned TICK_MS = 10;
	localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned TICKS_PER_S = 1000 / TICK_MS;
	localparam int unsigned FREEZE_S = 10;
	localparam logic [11:0] FREEZE_TK = 12'(FREEZE_S * TICKS_PER_S);

	// ==========================================================
	// high priority burst, in ticks except HP_PERIOD_S in seconds
	localparam int unsigned HP_PERIOD_S = 10;
	localparam logic [11:0] HP_PERIOD_TK = 12'(HP_PERIOD_S * TICKS_PER_S);
	localparam logic [11:0] HP_BEEP_TK = 12'h00A;
	localparam logic [11:0] HP_STEP_TK = 12'h014;
	localparam logic [11:0] HP_GRP2_TK = 12'h046;
	localparam logic [11:0] HP_PATT_TK = 12'h064;
	localparam logic [11:0] HP_REPEAT_TK = 12'h0C8;
	localparam logic [11:0] HP_BURST_TK = 12'h12C;

	// ==========================================================
	// medium priority burst, in ticks except MED_PERIOD_S in seconds
	localparam int unsigned MED_PERIOD_S = 25;
	localparam logic [11:0] MED_PERIOD_TK = 12'(MED_PERIOD_S * TICKS_PER_S);
	localparam logic [11:0] MED_BEEP_TK = 12'h019;
	localparam logic [11:0] MED_STEP_TK = 12'h023;
	localparam logic [11:0] MED_BURST_TK = 12'h064;

	// informational beep length in ticks
	localparam logic [11:0] INFO_BEEP_TK = 12'h00A;

	// ==========================================================
	// breath detection, pitch and volume codes
	localparam logic [8:0] BREATH_DELTA_MMHG = 9'h005;
	localparam logic [3:0] PITCH_FIXED = 4'hB;
	localparam logic [1:0] VOL_OFF = 2'h0;
	localparam logic [1:0] VOL_LOW = 2'h1;
	localparam logic [1:0] VOL_MED = 2'h2;
	localparam logic [1:0] VOL_HIGH = 2'h3;
	localparam logic [1:0] ALARM_VOLUME = 2'h3;

	// ==========================================================
	// display digit masks, bit 2 is the leftmost digit
	localparam logic [2:0] DASH_NONE = 3'h0;
	localparam logic [2:0] DASH_LEFT = 3'h4;
	localparam logic [2:0] DASH_MID = 3'h2;
	localparam logic [2:0] DASH_ALL = 3'h7;

	typedef enum logic [1:0] {TONE_IDLE, TONE_HIGH, TONE_MED} tone_mode_e;
	typedef enum logic {BR_TROUGH, BR_PEAK} breath_state_e;

endpackage

// ---- include/tone_if.sv ----
/*
 * Carrier between the alarm controller and its tone sequencer.
 * Assumes both ends run on core_clk; tick is a one-cycle 10 ms enable.
 */
`timescale 1ns/1ns
interface tone_if;
	logic tick;
	logic req_high;
	logic req_med;
	logic beep_req;
	logic [3:0] beep_pitch;
	logic alarm_busy;
	logic tone_on;
	logic tone_alarm;
	logic [3:0] tone_pitch;

	modport ctrl (
		output tick, req_high, req_med, beep_req, beep_pitch,
		input alarm_busy, tone_on, tone_alarm, tone_pitch
	);
	modport seq (
		input tick, req_high, req_med, beep_req, beep_pitch,
		output alarm_busy, tone_on, tone_alarm, tone_pitch
	);
endinterface

// ---- rtl/tone_sequencer.sv ----
/*
 * Speaker sequencer: plays one alarm burst pattern or one informational beep.
 * Assumes requests arrive on core_clk and the tick strobe comes from the controller.
 */
`timescale 1ns/1ns
module tone_sequencer
	import alarm_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	tone_if.seq tf
);

	tone_mode_e mode;
	logic [11:0] pos;
	logic beep_pend;
	logic beep_act;
	logic [11:0] beep_cnt;
	logic [3:0] beep_pitch_q;
	logic in_burst;
	logic alarm_sound;

	// high burst envelope at a position in the period
	function automatic logic hp_on(input logic [11:0] p);
		logic [11:0] q;
		q = (p >= HP_REPEAT_TK) ? p - HP_REPEAT_TK : p;
		if (q < HP_GRP2_TK) begin
			hp_on = (q < 12'(3 * HP_STEP_TK)) && ((q % HP_STEP_TK) < HP_BEEP_TK);
		end else if (q < HP_PATT_TK) begin
			hp_on = ((q - HP_GRP2_TK) % HP_STEP_TK) < HP_BEEP_TK;
		end else begin
			hp_on = 1'b0;
		end
	endfunction

	// medium burst envelope
	function automatic logic med_on(input logic [11:0] p);
		med_on = (p < MED_BURST_TK) && ((p % MED_STEP_TK) < MED_BEEP_TK);
	endfunction

	assign in_burst = (mode == TONE_HIGH && pos < HP_BURST_TK)
		|| (mode == TONE_MED && pos < MED_BURST_TK);
	assign alarm_sound = (mode == TONE_HIGH) ? hp_on(pos) :
		(mode == TONE_MED) ? med_on(pos) : 1'b0;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			mode <= TONE_IDLE;
			pos <= 12'h000;
		end else if (tf.req_high) begin
			if (mode != TONE_HIGH) begin
				mode <= TONE_HIGH;
				pos <= 12'h000;
			end else if (tf.tick) begin
				pos <= (pos == HP_PERIOD_TK - 12'h001) ? 12'h000 : pos + 12'h001;
			end
		end else if (tf.req_med) begin
			if (mode != TONE_MED) begin
				mode <= TONE_MED;
				pos <= 12'h000;
			end else if (tf.tick) begin
				pos <= (pos == MED_PERIOD_TK - 12'h001) ? 12'h000 : pos + 12'h001;
			end
		end else begin
			mode <= TONE_IDLE;
			pos <= 12'h000;
		end
	end

	// informational beep waits for the silent gap
	always_ff @(posedge core_clk) begin
		if (reset) begin
			beep_pend <= 1'b0;
			beep_act <= 1'b0;
			beep_cnt <= 12'h000;
			beep_pitch_q <= 4'h0;
		end else begin
			if (tf.beep_req) begin
				beep_pend <= 1'b1;
				beep_pitch_q <= tf.beep_pitch;
			end else if (beep_pend && !beep_act && !in_burst) begin
				beep_pend <= 1'b0;
				beep_act <= 1'b1;
				beep_cnt <= 12'h000;
			end
			if (beep_act && (in_burst || (tf.tick && beep_cnt == INFO_BEEP_TK - 12'h001))) begin
				beep_act <= 1'b0;
			end else if (beep_act && tf.tick) begin
				beep_cnt <= beep_cnt + 12'h001;
			end
		end
	end

	// one tone at a time, alarm first
	assign tf.alarm_busy = (mode != TONE_IDLE);
	assign tf.tone_alarm = alarm_sound;
	assign tf.tone_on = alarm_sound || (beep_act && !in_burst);
	assign tf.tone_pitch = alarm_sound ? PITCH_FIXED : beep_pitch_q;

endmodule

// ---- rtl/alarm_indicator_control.sv ----
/*
 * Alarm and indicator controller: maps alarm conditions to tones and display patterns,
 * detects breaths for the breath beep, and keeps the breath beep volume.
 * Assumes condition inputs come from same-clock measurement logic; the advance
 * switch is an asynchronous pin and is synchronised here.
 */
`timescale 1ns/1ns
module alarm_indicator_control
	import alarm_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic batt_low,
	input wire logic batt_crit,
	input wire logic spo2_alarm,
	input wire logic pr_alarm,
	input wire logic pulse_poor,
	input wire logic no_breath,
	input wire logic oxi_fault,
	input wire logic co2_fault,
	input wire logic audible_disable,
	input wire logic fixed_pitch,
	input wire logic init_beep,
	input wire logic [7:0] co2_mmhg,
	input wire logic [3:0] bar_count,
	input wire logic advance_pin,
	output logic batt_ind_on,
	output logic batt_ind_blink,
	output logic display_blank,
	output logic spo2_blink,
	output logic pr_blink,
	output logic [2:0] spo2_dash,
	output logic [2:0] pr_dash,
	output logic display_freeze,
	output logic pq_red_blink,
	output logic no_breath_flash,
	output logic bar_enable,
	output logic bar_fault,
	output logic audible_enabled,
	output logic spk_on,
	output logic [3:0] spk_pitch,
	output logic [1:0] spk_volume,
	output logic [1:0] beep_volume
);

	tone_if tf();

	// ==========================================================
	// tick divider and tone sequencer
	logic [31:0] tick_cnt;
	logic tick;

	// 10 ms enable pulse from the core clock
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
			tick <= 1'b0;
		end
	end

	tone_sequencer u_seq (
		.core_clk(core_clk),
		.reset(reset),
		.tf(tf.seq)
	);

	// ==========================================================
	// advance switch synchroniser
	logic adv_s1;
	logic adv_s2;
	logic adv_s3;
	logic adv_press;

	// two flops, then edge detect on the second
	always_ff @(posedge core_clk) begin
		if (reset) begin
			adv_s1 <= 1'b0;
			adv_s2 <= 1'b0;
			adv_s3 <= 1'b0;
		end else begin
			adv_s1 <= advance_pin;
			adv_s2 <= adv_s1;
			adv_s3 <= adv_s2;
		end
	end
	assign adv_press = adv_s2 && !adv_s3;

	// ==========================================================
	// critical battery latching
	logic crit_q;
	logic lat_spo2;
	logic lat_pr;
	logic lat_pq;
	logic lat_nb;
	logic crit_any_lat;

	// capture patient alarms present as the critical state starts
	always_ff @(posedge core_clk) begin
		if (reset) begin
			crit_q <= 1'b0;
			lat_spo2 <= 1'b0;
			lat_pr <= 1'b0;
			lat_pq <= 1'b0;
			lat_nb <= 1'b0;
		end else begin
			crit_q <= batt_crit;
			if (!batt_crit) begin
				lat_spo2 <= 1'b0;
				lat_pr <= 1'b0;
				lat_pq <= 1'b0;
				lat_nb <= 1'b0;
			end else if (!crit_q) begin
				lat_spo2 <= spo2_alarm;
				lat_pr <= pr_alarm;
				lat_pq <= pulse_poor;
				lat_nb <= no_breath;
			end
		end
	end
	assign crit_any_lat = lat_spo2 || lat_pr || lat_pq || lat_nb;

	// ==========================================================
	// oximeter fault timing and carbon dioxide fault latching
	logic oxi_q;
	logic [11:0] oxi_tk;
	logic oxi_phase2;
	logic oxi_lat_spo2;
	logic oxi_lat_pr;
	logic co2_q;
	logic co2_lat_nb;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			oxi_q <= 1'b0;
			oxi_tk <= 12'h000;
			oxi_phase2 <= 1'b0;
			oxi_lat_spo2 <= 1'b0;
			oxi_lat_pr <= 1'b0;
		end else begin
			oxi_q <= oxi_fault;
			if (!oxi_fault) begin
				oxi_tk <= 12'h000;
				oxi_phase2 <= 1'b0;
				oxi_lat_spo2 <= 1'b0;
				oxi_lat_pr <= 1'b0;
			end else if (!oxi_q) begin
				oxi_tk <= 12'h000;
				oxi_lat_spo2 <= spo2_alarm;
				oxi_lat_pr <= pr_alarm;
			end else if (tick && !oxi_phase2) begin
				if (oxi_tk == FREEZE_TK - 12'h001) begin
					oxi_phase2 <= 1'b1;
				end else begin
					oxi_tk <= oxi_tk + 12'h001;
				end
			end
		end
	end

	// hold a no breath alarm present when the sensor faults
	always_ff @(posedge core_clk) begin
		if (reset) begin
			co2_q <= 1'b0;
			co2_lat_nb <= 1'b0;
		end else begin
			co2_q <= co2_fault;
			if (!co2_fault) begin
				co2_lat_nb <= 1'b0;
			end else if (!co2_q) begin
				co2_lat_nb <= no_breath;
			end
		end
	end

	// ==========================================================
	// audible alarm requests
	logic aud_en;
	logic hp_now;
	logic hp_aud;
	logic med_aud;

	// critical battery overrides the disable switch
	assign aud_en = !audible_disable || batt_crit;
	assign hp_now = spo2_alarm || pr_alarm || pulse_poor || no_breath;
	assign hp_aud = batt_crit ? crit_any_lat :
		aud_en && (hp_now || co2_lat_nb || oxi_lat_spo2 || oxi_lat_pr);
	assign med_aud = batt_crit ? !hp_now && !crit_any_lat :
		aud_en && (oxi_fault || co2_fault);

	assign tf.tick = tick;
	assign tf.req_high = hp_aud;
	assign tf.req_med = med_aud;

	// ==========================================================
	// breath detection
	breath_state_e br_state;
	logic [7:0] br_trough;
	logic [7:0] br_peak;
	logic br_beep;

	// five mmHg swing marks one breath, one beep
	always_ff @(posedge core_clk) begin
		if (reset) begin
			br_state <= BR_TROUGH;
			br_trough <= 8'hFF;
			br_peak <= 8'h00;
			br_beep <= 1'b0;
		end else begin
			br_beep <= 1'b0;
			case (br_state)
				BR_TROUGH: begin
					if (co2_mmhg < br_trough) begin
						br_trough <= co2_mmhg;
					end else if ({1'b0, co2_mmhg} >= {1'b0, br_trough} + BREATH_DELTA_MMHG) begin
						br_state <= BR_PEAK;
						br_peak <= co2_mmhg;
						br_beep <= fixed_pitch;
					end
				end
				BR_PEAK: begin
					if (co2_mmhg > br_peak) begin
						br_peak <= co2_mmhg;
					end else if ({1'b0, co2_mmhg} + BREATH_DELTA_MMHG <= {1'b0, br_peak}) begin
						br_state <= BR_TROUGH;
						br_trough <= co2_mmhg;
						br_beep <= !fixed_pitch;
					end
				end
				default: begin
					br_state <= BR_TROUGH;
					br_trough <= 8'hFF;
				end
			endcase
		end
	end

	// ==========================================================
	// breath beep volume and informational beep requests
	logic [1:0] vol;
	logic vol_beep;

	// power-on medium, press cycles low medium high off
	always_ff @(posedge core_clk) begin
		if (reset) begin
			vol <= VOL_MED;
		end else if (adv_press) begin
			case (vol)
				VOL_LOW: vol <= VOL_MED;
				VOL_MED: vol <= VOL_HIGH;
				VOL_HIGH: vol <= VOL_OFF;
				default: vol <= VOL_LOW;
			endcase
		end
	end

	// volume beep unless an alarm is in progress
	always_ff @(posedge core_clk) begin
		if (reset) begin
			vol_beep <= 1'b0;
		end else begin
			vol_beep <= adv_press && !tf.alarm_busy;
		end
	end

	// fixed pitch for init and volume beeps
	assign tf.beep_req = vol_beep || init_beep || br_beep;
	assign tf.beep_pitch = (vol_beep || init_beep || fixed_pitch) ? PITCH_FIXED : bar_count;

	// ==========================================================
	// speaker outputs
	// alarms always at their own fixed loudness
	always_ff @(posedge core_clk) begin
		if (reset) begin
			spk_on <= 1'b0;
			spk_pitch <= 4'h0;
			spk_volume <= VOL_OFF;
			beep_volume <= VOL_MED;
			audible_enabled <= 1'b0;
		end else begin
			spk_on <= tf.tone_on;
			spk_pitch <= tf.tone_pitch;
			spk_volume <= tf.tone_alarm ? ALARM_VOLUME : vol;
			beep_volume <= vol;
			audible_enabled <= aud_en;
		end
	end

	// ==========================================================
	// visible indications
	logic next_batt_on;
	logic next_batt_blink;
	logic next_blank;
	logic next_spo2_blink;
	logic next_pr_blink;
	logic [2:0] next_spo2_dash;
	logic [2:0] next_pr_dash;
	logic next_freeze;
	logic next_pq;
	logic next_nb;
	logic next_bar_en;
	logic next_bar_fault;

	// pattern selection by condition
	always_comb begin
		next_batt_on = 1'b0;
		next_batt_blink = 1'b0;
		next_blank = 1'b0;
		next_spo2_blink = 1'b0;
		next_pr_blink = 1'b0;
		next_spo2_dash = DASH_NONE;
		next_pr_dash = DASH_NONE;
		next_freeze = 1'b0;
		next_pq = 1'b0;
		next_nb = 1'b0;
		next_bar_en = 1'b1;
		next_bar_fault = 1'b0;
		if (batt_crit) begin
			next_batt_on = 1'b1;
			next_batt_blink = 1'b1;
			next_blank = 1'b1;
			next_bar_en = 1'b0;
			next_spo2_dash = lat_spo2 ? DASH_ALL : DASH_NONE;
			next_pr_dash = lat_pr ? DASH_ALL : DASH_NONE;
			next_spo2_blink = lat_spo2;
			next_pr_blink = lat_pr;
			next_pq = lat_pq;
			next_nb = lat_nb;
		end else begin
			next_batt_on = batt_low;
			next_spo2_blink = spo2_alarm;
			next_pr_blink = pr_alarm;
			next_pq = pulse_poor;
			// no breath flash with live bars
			next_nb = no_breath || co2_lat_nb;
			if (oxi_fault) begin
				next_freeze = !oxi_phase2;
				next_spo2_dash = oxi_phase2 ? (DASH_LEFT | DASH_MID) : DASH_LEFT;
				next_pr_dash = oxi_phase2 ? DASH_MID : DASH_NONE;
				next_spo2_blink = oxi_lat_spo2;
				next_pr_blink = oxi_lat_pr;
			end
			if (co2_fault) begin
				next_bar_en = 1'b0;
				next_bar_fault = 1'b1;
			end
		end
	end

	// registered display outputs
	always_ff @(posedge core_clk) begin
		if (reset) begin
			batt_ind_on <= 1'b0;
			batt_ind_blink <= 1'b0;
			display_blank <= 1'b0;
			spo2_blink <= 1'b0;
			pr_blink <= 1'b0;
			spo2_dash <= DASH_NONE;
			pr_dash <= DASH_NONE;
			display_freeze <= 1'b0;
			pq_red_blink <= 1'b0;
			no_breath_flash <= 1'b0;
			bar_enable <= 1'b0;
			bar_fault <= 1'b0;
		end else begin
			batt_ind_on <= next_batt_on;
			batt_ind_blink <= next_batt_blink;
			display_blank <= next_blank;
			spo2_blink <= next_spo2_blink;
			pr_blink <= next_pr_blink;
			spo2_dash <= next_spo2_dash;
			pr_dash <= next_pr_dash;
			display_freeze <= next_freeze;
			pq_red_blink <= next_pq;
			no_breath_flash <= next_nb;
			bar_enable <= next_bar_en;
			bar_fault <= next_bar_fault;
		end
	end

endmodule

// ---- tb/alarm_control_asserts.sv ----
/*
 * Concurrent checks on the alarm and indicator controller ports.
 * Assumes a bind from the bench top; tick length comes in as TICK_CYCLES.
 */
`timescale 1ns/1ns
module alarm_control_asserts
	import alarm_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic batt_low,
	input wire logic batt_crit,
	input wire logic spo2_alarm,
	input wire logic pulse_poor,
	input wire logic no_breath,
	input wire logic oxi_fault,
	input wire logic co2_fault,
	input wire logic batt_ind_on,
	input wire logic batt_ind_blink,
	input wire logic display_blank,
	input wire logic spo2_blink,
	input wire logic [2:0] spo2_dash,
	input wire logic [2:0] pr_dash,
	input wire logic display_freeze,
	input wire logic pq_red_blink,
	input wire logic no_breath_flash,
	input wire logic bar_enable,
	input wire logic bar_fault,
	input wire logic audible_enabled,
	input wire logic [1:0] beep_volume
);
	localparam int FRZ_MAX = int'(FREEZE_TK) * int'(TICK_CYCLES) + 4;
	// the first counted tick may come up to one tick after the fault, so allow one tick short
	localparam int FRZ_MIN = int'(FREEZE_TK) * int'(TICK_CYCLES) - int'(TICK_CYCLES);
	logic [31:0] frz_cnt;

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	// ==========================================================
	// freeze length counter
	always_ff @(posedge core_clk) begin
		if (reset || !display_freeze) begin
			frz_cnt <= '0;
		end else begin
			frz_cnt <= frz_cnt + 32'h1;
		end
	end

	// ==========================================================
	// assertions
	low_steady_a: assert property ((batt_low && !batt_crit)[*2]
		|-> batt_ind_on && !batt_ind_blink)
		else $error("low battery indicator not steady");
	crit_blank_a: assert property (batt_crit[*2]
		|-> display_blank && batt_ind_blink && !bar_enable)
		else $error("critical battery display wrong");
	crit_audible_a: assert property (batt_crit[*2] |-> audible_enabled)
		else $error("critical battery left audible disabled");
	limit_blink_a: assert property ((spo2_alarm && !batt_crit && !oxi_fault)[*2] |-> spo2_blink)
		else $error("saturation alarm not blinking");
	pulse_red_a: assert property ((pulse_poor && !batt_crit)[*2] |-> pq_red_blink)
		else $error("poor pulse not shown red");
	breath_flash_a: assert property ((no_breath && !batt_crit && !co2_fault)[*2]
		|-> no_breath_flash && bar_enable)
		else $error("no breath flash or bar graph wrong");
	oxi_dash_a: assert property ($rose(oxi_fault) && !batt_crit
		|-> ##[1:3] spo2_dash[2] && display_freeze)
		else $error("oximeter fault dash late");
	freeze_max_a: assert property (frz_cnt <= FRZ_MAX)
		else $error("freeze held too long");
	mid_dash_a: assert property ($fell(display_freeze) && oxi_fault
		|-> frz_cnt >= FRZ_MIN && spo2_dash == 3'h6 && pr_dash == 3'h2)
		else $error("middle dashes wrong after freeze");
	co2_bars_a: assert property ((co2_fault && !batt_crit)[*2] |-> bar_fault)
		else $error("sensor fault bars missing");
	volume_step_a: assert property ($changed(beep_volume)
		|-> beep_volume == $past(beep_volume) + 2'h1)
		else $error("volume stepped out of order");

	// main scenarios reached
	crit_c: cover property (batt_crit ##1 display_blank);
	freeze_c: cover property ($fell(display_freeze) && oxi_fault);
	vol_c: cover property ($changed(beep_volume));
endmodule

// ---- tb/alarm_indicator_control_tb.sv ----
/*
 * Self-checking bench for the alarm and indicator controller.
 * Assumes the bench drives every input on the falling edge; short tick of 10 cycles.
 */
`timescale 1ns/1ns
module alarm_indicator_control_tb
	import alarm_pkg::*;
;
	localparam int unsigned TICK_CYCLES = 10;
	logic core_clk = 0, reset = 1, batt_low = 0, batt_crit = 0, spo2_alarm = 0, pr_alarm = 0;
	logic pulse_poor = 0, no_breath = 0, oxi_fault = 0, co2_fault = 0, audible_disable = 0;
	logic fixed_pitch = 0, init_beep = 0, advance_pin = 0, spk_q = 0;
	logic [7:0] co2_mmhg = 8'h00;
	logic [3:0] bar_count = 4'h6;
	logic batt_ind_on, batt_ind_blink, display_blank, spo2_blink, pr_blink, display_freeze;
	logic pq_red_blink, no_breath_flash, bar_enable, bar_fault, audible_enabled, spk_on;
	logic [2:0] spo2_dash, pr_dash;
	logic [3:0] spk_pitch;
	logic [1:0] spk_volume, beep_volume;
	int err_total = 0, tests_run = 0, beeps = 0, cyc = 0, b0 = 0;
	logic [1:0] vols [4] = '{2'h3, 2'h0, 2'h1, 2'h2};

	alarm_indicator_control #(.TICK_CYCLES(TICK_CYCLES)) u_alarm_indicator_control (.*);

	// ==========================================================
	// clock, beep counter and timeout
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		spk_q <= spk_on;
		if (spk_on && !spk_q) beeps <= beeps + 1;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			complete_run();
		end
	end

	// ==========================================================
	// helpers
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wait_spk();
		for (int i = 0; i < 400 && spk_on !== 1'b1; i++) @(negedge core_clk);
		chk("spk_on", spk_on, 1);
	endtask
	// on, off, on probes after a burst starts
	task automatic burst(input int a, input int b, input int c);
		wait_spk();
		step(a);
		chk("burst on", spk_on, 1);
		step(b - a);
		chk("burst gap", spk_on, 0);
		step(c - b);
		chk("burst again", spk_on, 1);
	endtask
	task automatic clear_all();
		{batt_low, batt_crit, spo2_alarm, pr_alarm} = '0;
		{pulse_poor, no_breath, oxi_fault, co2_fault} = '0;
		step(20);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		step(2);
		reset = 0;
		step(2);
		chk("beep_volume", beep_volume, VOL_MED);
		batt_low = 1;
		b0 = beeps;
		step(200);
		chk("batt_ind_on", batt_ind_on, 1);
		chk("batt_ind_blink", batt_ind_blink, 0);
		chk("low quiet", beeps - b0, 0);
		clear_all();
		spo2_alarm = 1;
		pr_alarm = 1;
		co2_fault = 1;
		step(3);
		chk("spo2_blink", spo2_blink, 1);
		chk("pr_blink", pr_blink, 1);
		chk("bar_fault", bar_fault, 1);
		burst(50, 150, 250);
		batt_crit = 1;
		step(4);
		chk("spo2_dash", spo2_dash, DASH_ALL);
		chk("pr_dash", pr_dash, DASH_ALL);
		chk("display_blank", display_blank, 1);
		chk("batt_ind_blink", batt_ind_blink, 1);
		chk("crit bar_fault", bar_fault, 0);
		chk("crit bar_enable", bar_enable, 0);
		wait_spk();
		chk("alarm volume", spk_volume, ALARM_VOLUME);
		clear_all();
		audible_disable = 1;
		batt_crit = 1;
		step(3);
		chk("audible_enabled", audible_enabled, 1);
		burst(200, 300, 400);
		chk("med volume", spk_volume, ALARM_VOLUME);
		clear_all();
		chk("disabled again", audible_enabled, 0);
		audible_disable = 0;
		pulse_poor = 1;
		no_breath = 1;
		step(3);
		chk("pq_red_blink", pq_red_blink, 1);
		chk("no_breath_flash", no_breath_flash, 1);
		chk("bar_enable", bar_enable, 1);
		batt_crit = 1;
		step(4);
		chk("latched pq", pq_red_blink, 1);
		chk("latched flash", no_breath_flash, 1);
		chk("crit bars off", bar_enable, 0);
		clear_all();
		oxi_fault = 1;
		step(3);
		chk("left dash", spo2_dash, DASH_LEFT);
		chk("freeze", display_freeze, 1);
		wait_spk();
		step(9900);
		chk("still frozen", display_freeze, 1);
		step(110);
		chk("unfrozen", display_freeze, 0);
		chk("spo2 mid dash", spo2_dash, 3'h6);
		chk("pr mid dash", pr_dash, DASH_MID);
		clear_all();
		step(200);
		// power-on beep keeps the fixed pitch in variable mode
		init_beep = 1;
		step(1);
		init_beep = 0;
		wait_spk();
		chk("init pitch", spk_pitch, PITCH_FIXED);
		step(150);
		// volume steps, each with a fixed pitch beep
		foreach (vols[i]) begin
			advance_pin = 1;
			wait_spk();
			chk("beep_volume", beep_volume, vols[i]);
			chk("vol pitch", spk_pitch, PITCH_FIXED);
			chk("vol level", spk_volume, vols[i]);
			advance_pin = 0;
			step(150);
		end
		co2_mmhg = 8'h0A;
		step(30);
		chk("no rise beep", spk_on, 0);
		co2_mmhg = 8'h02;
		wait_spk();
		chk("var pitch", spk_pitch, bar_count);
		step(150);
		fixed_pitch = 1;
		b0 = beeps;
		co2_mmhg = 8'h0A;
		wait_spk();
		chk("fixed pitch", spk_pitch, PITCH_FIXED);
		step(300);
		chk("one beep", beeps - b0, 1);
		complete_run();
	end
endmodule

bind alarm_indicator_control alarm_control_asserts #(.TICK_CYCLES(TICK_CYCLES))
	u_alarm_control_asserts (.*);
